// >>> fsr_pkg.sv
// package for the flash status poller: constants, state and carrier types
package fsr_pkg;
   // ************************************************************
   // apb register map of the controller
   // ************************************************************
   localparam logic [7:0]  REG_CTRL    = 8'h00;  // command / start register
   localparam logic [7:0]  REG_ADDR    = 8'h04;  // flash word address
   localparam logic [7:0]  REG_WDATA   = 8'h08;  // program data / command word
   localparam logic [7:0]  REG_STATUS  = 8'h0C;  // controller status
   localparam logic [7:0]  REG_RESULT  = 8'h10;  // last word read: status or array data
   // ************************************************************
   // control register fields
   // ************************************************************
   localparam int CTRL_START   = 0;   // write 1: begin an action
   localparam int CTRL_MODE_LO = 1;   // action code, two bits
   localparam int CTRL_MODE_HI = 2;
   localparam logic [1:0] ACT_WRITE = 2'h0;  // single bus write cycle
   localparam logic [1:0] ACT_SREG  = 2'h1;  // read status register until ready
   localparam logic [1:0] ACT_POLL  = 2'h2;  // data-polling wait at address
   localparam logic [1:0] ACT_READ  = 2'h3;  // single bus read cycle
   // ************************************************************
   // status register bit positions
   // ************************************************************
   localparam int SR_READY    = 7;
   localparam int SR_ESUSP    = 6;
   localparam int SR_ERASE    = 5;
   localparam int SR_PROG     = 4;
   localparam int SR_ABORT    = 3;
   localparam int SR_PSUSP    = 2;
   localparam int SR_LOCK     = 1;
   localparam logic [15:0] SR_VALID_MASK  = 16'h00_7E;  // bits 6..1
   localparam logic [15:0] SR_USED_MASK   = 16'h00_FE;  // bits 7..1
   localparam logic [15:0] POLL_USED_MASK = 16'h00_EE;  // 7,6,5,3,2,1
   localparam int DQ_POLL   = 7;
   localparam int DQ_TOG    = 6;
   localparam int DQ_LIMIT  = 5;
   localparam int DQ_STARTD = 3;
   localparam int DQ_TOG2   = 2;
   localparam int DQ_ABORT  = 1;
   // ************************************************************
   // bus timing (ns) and derived counts at 100 mhz
   // ************************************************************
   localparam int CLK_NS       = 10;
   localparam int T_STROBE_NS  = 100;  // least strobe low time
   localparam int T_HOLD_NS    = 30;   // least strobe high time
   localparam int STROBE_CYC   = (T_STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int HOLD_CYC     = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [15:0] CMD_SREG_READ = 16'h00_70;  // status read command
   localparam logic [15:0] CMD_ADDR      = 16'h05_55;  // command address
   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [6:0] {
      ST_IDLE  = 7'b000_0001,
      ST_WR    = 7'b000_0010,
      ST_WHOLD = 7'b000_0100,
      ST_RD    = 7'b000_1000,
      ST_RHOLD = 7'b001_0000,
      ST_EVAL  = 7'b010_0000,
      ST_DONE  = 7'b100_0000
   } fsr_state_t;
   typedef struct packed {
      logic [22:0] addr;   // word address
      logic [15:0] dq_o;   // data out
      logic        dq_oe;  // data drive enable
      logic        ce_n;   // chip select, active low
      logic        oe_n;   // output enable, active low
      logic        we_n;   // write strobe, active low
   } fsr_bus_t;
endpackage

// >>> fsr_ctrl.sv
// host controller that issues flash bus cycles and polls operation status
//
// Notes on behaviour
// - mask reserved status bits 15..8 and 0
// - ignore bits 6..1 while ready is 0
// - after suspend, read status until ready
// - poll at last loaded word address
// - erase: bit 7 zero, one when done
// - take array data on following read
// - recheck bit 7 after timeout bit
// - bit 3 one means erase began
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module fsr_ctrl #(
   parameter int ADDR_W = 23
) (
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic [ADDR_W-1:0] fl_addr,
   output logic             fl_ce_n,
   output logic             fl_oe_n,
   output logic             fl_we_n,
   input  wire logic [15:0] fl_dq_i,
   output logic [15:0]      fl_dq_o,
   output logic             fl_dq_oe
);
   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      fsr_pkg::fsr_state_t st;     // sequencer state
      logic [1:0]          act;    // current action
      logic [ADDR_W-1:0]   addr;   // target address
      logic [15:0]         wdata;  // data / expected value
      logic [15:0]         dq_s1;  // pin sync stage one
      logic [15:0]         dq_s2;  // pin sync stage two
      logic [15:0]         last;   // previous status word
      logic [15:0]         result; // last word read
      logic                have;   // previous word valid
      logic                busy;   // action running
      logic                fail;   // poll ended in failure
      logic                sr_cmd; // status command phase done
      logic [7:0]          cnt;    // strobe timer
      logic [ADDR_W-1:0]   bus_a;  // driven address
      logic [15:0]         bus_d;  // driven data
      logic                dq_oe;  // data drive enable
      logic                ce_n;
      logic                oe_n;
      logic                we_n;
   } fsr_reg_t;
   fsr_reg_t r_q;  // registered state
   fsr_reg_t r_d;  // next state
   logic     wr_hit;  // apb write access
   // ************************************************************
   // helpers
   // ************************************************************
   // status valid bits only once ready, reserved bits dropped
   function automatic logic [15:0] sreg_view(input logic [15:0] w);
      if (w[fsr_pkg::SR_READY]) begin
         sreg_view = w & fsr_pkg::SR_USED_MASK;
      end else begin
         sreg_view = w & (fsr_pkg::SR_USED_MASK & ~fsr_pkg::SR_VALID_MASK);
      end
   endfunction
   assign wr_hit = psel && penable && pwrite;
   assign pready = 1'b1;  // zero wait states
   assign pslverr = 1'b0;
   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      r_d = r_q;
      r_d.dq_s1 = fl_dq_i;  // two flops before use
      r_d.dq_s2 = r_q.dq_s1;
      // apb writes steer the sequencer
      if (wr_hit && !r_q.busy) begin
         unique case (paddr)
            fsr_pkg::REG_ADDR: begin
               r_d.addr = pwdata[ADDR_W-1:0];
            end
            fsr_pkg::REG_WDATA: begin
               r_d.wdata = pwdata[15:0];
            end
            fsr_pkg::REG_CTRL: begin
               if (pwdata[fsr_pkg::CTRL_START]) begin
                  r_d.act = pwdata[fsr_pkg::CTRL_MODE_HI:fsr_pkg::CTRL_MODE_LO];
                  r_d.busy = 1'b1;
                  r_d.fail = 1'b0;
                  r_d.have = 1'b0;
                  r_d.sr_cmd = 1'b0;
               end
            end
            default: begin
               r_d.busy = r_q.busy;  // unmapped: ignored
            end
         endcase
      end
      unique case (r_q.st)
         fsr_pkg::ST_IDLE: begin
            r_d.cnt = '0;
            if (r_d.busy && !r_q.busy) begin
               if (r_d.act == fsr_pkg::ACT_WRITE) begin
                  r_d.st = fsr_pkg::ST_WR;
                  r_d.bus_a = r_d.addr;
                  r_d.bus_d = r_d.wdata;
               end else if (r_d.act == fsr_pkg::ACT_SREG) begin
                  // status register needs its read command first
                  r_d.st = fsr_pkg::ST_WR;
                  r_d.bus_a = ADDR_W'(fsr_pkg::CMD_ADDR);
                  r_d.bus_d = fsr_pkg::CMD_SREG_READ;
               end else begin
                  r_d.st = fsr_pkg::ST_RD;  // poll or single read at given address
                  r_d.bus_a = r_d.addr;
               end
            end
         end
         fsr_pkg::ST_WR: begin
            r_d.ce_n = 1'b0;
            r_d.we_n = 1'b0;
            r_d.dq_oe = 1'b1;
            r_d.cnt = r_q.cnt + 8'd1;
            if (r_q.cnt == 8'(fsr_pkg::STROBE_CYC)) begin
               r_d.we_n = 1'b1;  // status valid after this rising edge
               r_d.cnt = '0;
               r_d.st = fsr_pkg::ST_WHOLD;
            end
         end
         fsr_pkg::ST_WHOLD: begin
            r_d.ce_n = 1'b1;
            r_d.dq_oe = 1'b0;
            r_d.cnt = r_q.cnt + 8'd1;
            if (r_q.cnt == 8'(fsr_pkg::HOLD_CYC)) begin
               r_d.cnt = '0;
               if (r_q.act == fsr_pkg::ACT_SREG) begin
                  r_d.sr_cmd = 1'b1;
                  r_d.st = fsr_pkg::ST_RD;
               end else begin
                  r_d.st = fsr_pkg::ST_DONE;
               end
            end
         end
         fsr_pkg::ST_RD: begin
            // each read cycle is a fresh ce/oe pulse so toggles advance
            r_d.ce_n = 1'b0;
            r_d.oe_n = 1'b0;
            r_d.cnt = r_q.cnt + 8'd1;
            if (r_q.cnt == 8'(fsr_pkg::STROBE_CYC) + 8'd2) begin
               r_d.result = r_q.dq_s2;  // sampled after sync delay
               r_d.ce_n = 1'b1;
               r_d.oe_n = 1'b1;
               r_d.cnt = '0;
               r_d.st = fsr_pkg::ST_RHOLD;
            end
         end
         fsr_pkg::ST_RHOLD: begin
            r_d.cnt = r_q.cnt + 8'd1;
            if (r_q.cnt == 8'(fsr_pkg::HOLD_CYC)) begin
               r_d.cnt = '0;
               r_d.st = fsr_pkg::ST_EVAL;
            end
         end
         fsr_pkg::ST_EVAL: begin
            r_d.st = fsr_pkg::ST_RD;
            if (r_q.act == fsr_pkg::ACT_READ) begin
               r_d.st = fsr_pkg::ST_DONE;
            end else if (r_q.act == fsr_pkg::ACT_SREG) begin
               // keep reading until ready, needed after suspend
               if (r_q.result[fsr_pkg::SR_READY]) begin
                  r_d.result = sreg_view(r_q.result);
                  r_d.fail = r_q.result[fsr_pkg::SR_ERASE] |
                             r_q.result[fsr_pkg::SR_PROG] |
                             r_q.result[fsr_pkg::SR_ABORT] |
                             r_q.result[fsr_pkg::SR_LOCK];
                  r_d.st = fsr_pkg::ST_DONE;
               end else begin
                  // status register read exits; reissue command
                  r_d.st = fsr_pkg::ST_WR;
                  r_d.bus_a = ADDR_W'(fsr_pkg::CMD_ADDR);
               end
            end else begin
               r_d.result = r_q.result & fsr_pkg::POLL_USED_MASK;
               r_d.last = r_q.result;
               r_d.have = 1'b1;
               if (r_q.have) begin
                  // true bit 7 and no bit 6 toggle: done; next read is data
                  if (r_q.result[fsr_pkg::DQ_POLL] == r_q.wdata[fsr_pkg::DQ_POLL] &&
                      r_q.result[fsr_pkg::DQ_TOG] == r_q.last[fsr_pkg::DQ_TOG]) begin
                     r_d.st = fsr_pkg::ST_RD;  // fresh read for data
                     r_d.act = fsr_pkg::ACT_READ;
                  end else if (r_q.last[fsr_pkg::DQ_LIMIT] || r_q.last[fsr_pkg::DQ_ABORT]) begin
                     // timeout or abort seen last read; this read rechecked bit 7
                     r_d.fail = 1'b1;
                     r_d.st = fsr_pkg::ST_DONE;
                  end
               end
            end
         end
         fsr_pkg::ST_DONE: begin
            r_d.busy = 1'b0;
            r_d.st = fsr_pkg::ST_IDLE;
         end
         default: begin
            r_d.st = fsr_pkg::ST_IDLE;
         end
      endcase
   end
   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         r_q <= '{st: fsr_pkg::ST_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      end else begin
         r_q <= r_d;
      end
   end
   // ************************************************************
   // outputs and apb read mux
   // ************************************************************
   assign fl_addr  = r_q.bus_a;
   assign fl_dq_o  = r_q.bus_d;
   assign fl_dq_oe = r_q.dq_oe;
   assign fl_ce_n  = r_q.ce_n;
   assign fl_oe_n  = r_q.oe_n;
   assign fl_we_n  = r_q.we_n;
   always_comb begin
      unique case (paddr)
         fsr_pkg::REG_ADDR:   prdata = 32'(r_q.addr);
         fsr_pkg::REG_WDATA:  prdata = {16'h0000, r_q.wdata};
         fsr_pkg::REG_STATUS: prdata = {30'h0000_0000, r_q.fail, r_q.busy};
         fsr_pkg::REG_RESULT: prdata = {16'h0000, r_q.result};  // bits 3,2 kept
         default:             prdata = 32'h0000_0000;
      endcase
   end
endmodule
`default_nettype wire

// >>> fsr_ctrl_props.sv
// checker of flash strobe timing and bus ownership for the status poller
`timescale 1ns/100ps
`default_nettype none
module fsr_ctrl_props #(
   parameter int ADDR_W = 23
) (
   input wire logic              clk_sys,
   input wire logic              rst,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic [ADDR_W-1:0] fl_addr,
   input wire logic              fl_ce_n,
   input wire logic              fl_oe_n,
   input wire logic              fl_we_n,
   input wire logic [15:0]       fl_dq_i,
   input wire logic [15:0]       fl_dq_o,
   input wire logic              fl_dq_oe
);
   // ************************************************************
   // strobe and data-bus properties, one clock domain
   // ************************************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_strobe_excl: assert property (fl_we_n || fl_oe_n)
      else $error("write and read strobes low together");
   a_we_selects: assert property (!fl_we_n |-> !fl_ce_n)
      else $error("write strobe without chip select");
   a_we_width: assert property ($fell(fl_we_n) |-> !fl_we_n [*8])
      else $error("write strobe too short");
   a_we_hold: assert property ($rose(fl_we_n) |-> fl_we_n [*4])
      else $error("write strobe high time too short");
   a_rd_width: assert property ($fell(fl_oe_n) |-> !fl_oe_n [*8])
      else $error("read strobe too short");
   a_rd_hold: assert property ($rose(fl_oe_n) |-> fl_oe_n [*4])
      else $error("read cycles not separated");
   a_addr_steady: assert property (!fl_ce_n && !$past(fl_ce_n) |-> $stable(fl_addr))
      else $error("address moved inside a cycle");
   a_data_steady: assert property (!fl_we_n && !$past(fl_we_n) |-> $stable(fl_dq_o) && fl_dq_oe)
      else $error("write data not held");
   a_no_contend: assert property (!fl_oe_n |-> !fl_dq_oe)
      else $error("host drives data during a read");
   // main scenarios reached
   c_write: cover property ($rose(fl_we_n));
   c_read: cover property ($rose(fl_oe_n));
   c_apb_write: cover property (psel && penable && pwrite);
endmodule
bind fsr_ctrl fsr_ctrl_props #(.ADDR_W(ADDR_W)) i_props (.clk_sys(clk_sys), .rst(rst),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .fl_addr(fl_addr),
   .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_dq_i(fl_dq_i),
   .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe));
`default_nettype wire

// >>> fsr_flash_model.sv
// behavioural parallel flash: status register, polling word, program, clear
`timescale 1ns/100ps
`default_nettype none
module fsr_flash_model #(
   parameter logic [22:0] LOCK_ADDR  = 23'h00_0100,  // protected word
   parameter logic [22:0] LIMIT_ADDR = 23'h00_0200,  // program that runs out of pulses
   parameter int          BUSY_READS = 3             // reads until a program ends
) (
   input  wire logic        rst,
   input  wire logic [22:0] addr,
   input  wire logic        ce_n,
   input  wire logic        oe_n,
   input  wire logic        we_n,
   input  wire logic [15:0] dq_o,
   output logic [15:0]      dq_i
);
   localparam logic [15:0] CMD_CLEAR = 16'h0050;  // clear status command
   logic [15:0] mem [0:1023];         // programmed words, low address bits
   logic [7:0]  sr        = 8'h00;    // status bits, bit 7 derived
   logic [15:0] pdata     = 16'h0000; // word being programmed
   logic [15:0] rdv       = 16'h0000; // word driven in a read
   logic [15:0] last      = 16'h0000; // last word driven
   logic [15:0] junk      = 16'hA5C3; // reserved bits, change every read
   logic        sreg_mode = 1'b0;     // next read returns status
   logic        tog       = 1'b0;     // toggle bit
   int          busy      = 0;        // reads left in a program
   logic        limit     = 1'b0;     // running program hit its pulse limit
   // erased array reads all ones
   initial begin
      for (int i = 0; i < 1024; i++) begin
         mem[i] = 16'hFFFF;
      end
   end
   // ************************************************************
   // commands taken at the write strobe's rising edge
   // ************************************************************
   always @(posedge rst or posedge we_n) begin
      if (rst) begin
         sr = 8'h00;
         sreg_mode = 1'b0;
         busy = 0;
      end else if (ce_n === 1'b0) begin
         if (dq_o === fsr_pkg::CMD_SREG_READ) begin
            sreg_mode = 1'b1;
         end else if (dq_o === CMD_CLEAR) begin
            sr = sr & 8'hC5;
         end else if (addr === LOCK_ADDR) begin
            sr[4] = 1'b1;
            sr[1] = 1'b1;
         end else begin
            mem[addr[9:0]] = dq_o;
            pdata = dq_o;
            busy = BUSY_READS;
            limit = (addr === LIMIT_ADDR);
            sr[4] = limit;
            sr[1] = 1'b0;
         end
      end
   end
   // read word chosen as the output strobe falls
   always @(negedge oe_n) begin
      if (sreg_mode) begin
         rdv = {junk[7:0], busy == 0, (busy == 0) ? sr[6:1] : junk[5:0], junk[0]};
      end else if (busy > 0) begin
         rdv = {junk[7:0], ~pdata[7], tog, limit, junk[1], 3'b000, junk[2]};
      end else begin
         rdv = mem[addr[9:0]];
      end
   end
   // each finished read advances the algorithm and leaves the status view
   always @(posedge oe_n) begin
      last = rdv;
      junk = {junk[14:0], ~junk[15]};
      sreg_mode = 1'b0;
      if (busy > 0) begin
         tog = ~tog;
         busy = busy - 1;
      end
   end
   // a released bus never repeats the last word
   assign dq_i = (!ce_n && !oe_n) ? rdv : ~last;
endmodule
`default_nettype wire

// >>> fsr_ctrl_tb_top.sv
// self-checking testbench of the flash status poller
`timescale 1ns/100ps
`default_nettype none
module fsr_ctrl_tb_top;
   logic        clk_sys;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic [22:0] fl_addr;
   logic        fl_ce_n;
   logic        fl_oe_n;
   logic        fl_we_n;
   logic [15:0] fl_dq_i;
   logic [15:0] fl_dq_o;
   logic        fl_dq_oe;
   logic [31:0] q;
   int          num_errors = 0;
   int          num_checks = 0;
   // ************************************************************
   // clock, design and flash
   // ************************************************************
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   fsr_ctrl i_dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(), .fl_addr(fl_addr), .fl_ce_n(fl_ce_n), .fl_oe_n(fl_oe_n),
      .fl_we_n(fl_we_n), .fl_dq_i(fl_dq_i), .fl_dq_o(fl_dq_o), .fl_dq_oe(fl_dq_oe));
   // an undriven data bus shows the inverse, so a missing drive enable spoils commands
   fsr_flash_model i_flash (.rst(rst), .addr(fl_addr), .ce_n(fl_ce_n), .oe_n(fl_oe_n),
      .we_n(fl_we_n), .dq_o(fl_dq_oe ? fl_dq_o : ~fl_dq_o), .dq_i(fl_dq_i));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   // start an action and wait until the controller is idle
   task automatic act(input logic [1:0] m, input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, fsr_pkg::REG_ADDR, a, r);
      apb(1'b1, fsr_pkg::REG_WDATA, d, r);
      apb(1'b1, fsr_pkg::REG_CTRL, {29'h0, m, 1'b1}, r);
      r = 32'h0000_0001;
      while (r[0] !== 1'b0) apb(1'b0, fsr_pkg::REG_STATUS, 32'h0000_0000, r);
   endtask
   task automatic act_chk(input logic [1:0] m, input logic [31:0] a, input logic [31:0] d,
                          input logic [31:0] er, input logic [31:0] es);
      logic [31:0] r;
      act(m, a, d);
      apb(1'b0, fsr_pkg::REG_RESULT, 32'h0000_0000, r);
      chk("result", r, er);
      apb(1'b0, fsr_pkg::REG_STATUS, 32'h0000_0000, r);
      chk("status", r, es);
   endtask
   // ************************************************************
   // tests and watchdog
   // ************************************************************
   initial begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'b0;
      apb(1'b0, 8'h20, 32'h0000_0000, q);
      chk("unmapped", q, 32'h0000_0000);
      act_chk(fsr_pkg::ACT_SREG, 32'h0, 32'h0, 32'h0000_0080, 32'h0);
      $display("test reset status done");
      act(fsr_pkg::ACT_WRITE, 32'h0000_0040, 32'h0000_12A5);
      act_chk(fsr_pkg::ACT_SREG, 32'h0, 32'h0, 32'h0000_0080, 32'h0);
      $display("test status while busy done");
      act(fsr_pkg::ACT_WRITE, 32'h0000_0044, 32'h0000_5A3C);
      act_chk(fsr_pkg::ACT_POLL, 32'h44, 32'h5A3C, 32'h0000_5A3C, 32'h0);
      act_chk(fsr_pkg::ACT_READ, 32'h40, 32'h0, 32'h0000_12A5, 32'h0);
      $display("test data polling done");
      act(fsr_pkg::ACT_WRITE, 32'h0000_0100, 32'h0000_1111);
      act_chk(fsr_pkg::ACT_SREG, 32'h0, 32'h0, 32'h0000_0092, 32'h2);
      act(fsr_pkg::ACT_WRITE, 32'h0000_0048, 32'h0000_0F0F);
      act_chk(fsr_pkg::ACT_SREG, 32'h0, 32'h0, 32'h0000_0080, 32'h0);
      act(fsr_pkg::ACT_WRITE, 32'h0000_0100, 32'h0000_1111);
      act(fsr_pkg::ACT_WRITE, 32'h0000_0555, 32'h0000_0050);
      act_chk(fsr_pkg::ACT_SREG, 32'h0, 32'h0, 32'h0000_0080, 32'h0);
      $display("test lock and clear done");
      act(fsr_pkg::ACT_WRITE, 32'h0000_0200, 32'h0000_0080);
      act(fsr_pkg::ACT_POLL, 32'h0000_0200, 32'h0000_0080);
      apb(1'b0, fsr_pkg::REG_RESULT, 32'h0000_0000, q);
      chk("poll limit bits", q & 32'h0000_00A0, 32'h0000_0020);
      apb(1'b0, fsr_pkg::REG_STATUS, 32'h0000_0000, q);
      chk("poll limit fail", q, 32'h0000_0002);
      act_chk(fsr_pkg::ACT_SREG, 32'h0, 32'h0, 32'h0000_0090, 32'h2);
      $display("test pulse limit done");
      print_verdict();
   end
   initial begin
      repeat (50000) @(posedge clk_sys);
      num_errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
